// ===== verilog/bx_exec_map.svh
// Offsets, field positions, reset values and opcodes of the branch and
// bit-set execute block. Assumes inclusion by bare name, once per unit.
`ifndef BX_EXEC_MAP_SVH
`define BX_EXEC_MAP_SVH
// --------------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------------
`define BX_OFF_CTRL 8'h00
`define BX_OFF_BANK 8'h04
`define BX_OFF_FLAGS 8'h08
`define BX_OFF_IBASE 8'h0c
`define BX_OFF_PC 8'h10
`define BX_OFF_MADDR 8'h14
`define BX_OFF_MDATA 8'h18
`define BX_OFF_STATE 8'h1c
// --------------------------------------------------------------------
// Fields and reset values
// --------------------------------------------------------------------
`define BX_CTRL_EXT_BIT 0
`define BX_FLAG_Z_BIT 0
`define BX_FLAG_OV_BIT 1
`define BX_FLAG_N_BIT 2
`define BX_RST_BANK 4'h0
`define BX_RST_FLAGS 3'h0
`define BX_RST_IBASE 12'h000
`define BX_RST_MADDR 12'h000
// --------------------------------------------------------------------
// Opcodes and addressing
// --------------------------------------------------------------------
`define BX_OP_NOT_NEG 8'he7
`define BX_OP_NOT_OVF 8'he5
`define BX_OP_NOT_ZERO 8'he1
`define BX_OP_ALWAYS 5'h1a
`define BX_OP_SET_BIT 4'h8
`define BX_ACCESS_LIMIT 8'h5f
`define BX_ACCESS_HIGH 4'hf
`define BX_PC_STEP 2
`endif

// ===== verilog/bx_exec_pkg.sv
// Types shared by the execute block and its testbench.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package bx_exec_pkg;
    typedef enum logic [1:0]
    {
        Q_DECODE = 2'b00,
        Q_READ = 2'b01,
        Q_PROCESS = 2'b10,
        Q_WRITE = 2'b11
    } phase_type;
    typedef logic [31:0] word_type;
    typedef logic [15:0] instr_type;
    typedef logic [7:0] byte_type;
endpackage
`default_nettype wire

// ===== verilog/data_mem_if.sv
// Port bundle between the execute logic and its file register memory.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface data_mem_if #(parameter int AW = 12);
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic we;
    modport master (output addr, output wdata, output we, input rdata);
    modport slave (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// ===== verilog/file_reg_mem.sv
// Banked file register memory, one byte per entry, registered read.
// Assumes the master holds addr for the cycle it wants data after.
`timescale 1ns/1ps
`default_nettype none
module file_reg_mem #(
    parameter int AW = 12
)(
    input wire logic clk_i,
    data_mem_if.slave mem
);
    logic [7:0] store [0:(1<<AW)-1];

    // No reset: contents are software state
    always_ff @(posedge clk_i)
    begin
        if (mem.we)
        begin
            store[mem.addr] <= mem.wdata;
        end
        mem.rdata <= store[mem.addr];
    end
endmodule
`default_nettype wire

// ===== verilog/branch_and_bit_set_execute.sv
// Quarter-phase executor for relative branches and the file bit set.
// Assumes a fetch stage on clk_i offering one word with a valid level.
// Contract
// - Branch_if_not_negative E7, taken when N clear
// - Branch_if_not_overflow E5, taken when OV clear
// - Branch_if_not_zero E1, taken when Z clear
// - Target is branch address plus 2 plus 2n
// - Conditional branch: one cycle, two if taken
// - Decode, read literal, process, write PC if taken
// - Branch_always 11010 with 11-bit offset always loads
// - Branch_always takes two cycles, second is no-op
// - Set_file_bit sets one bit, read-process-write
// - Bank bit clear: access bank, else bank register
// - Extended, bank bit clear, f<=5Fh: indexed base
`timescale 1ns/1ps
`default_nettype none
`include "bx_exec_map.svh"
module branch_and_bit_set_execute #(
    parameter int PC_W = 21,
    parameter int AW = 12
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire bx_exec_pkg::word_type wb_dat_i,
    output bx_exec_pkg::word_type wb_dat_o,
    output logic wb_ack_o,
    input wire bx_exec_pkg::instr_type instr_i,
    input wire logic instr_valid_i,
    output logic instr_ready_o,
    output logic [PC_W-1:0] pc_o
);
    import bx_exec_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (PC_W < 13 || PC_W > 32)
    begin : g_bad_pc
        $error("PC_W must lie in 13..32");
    end
    if (AW != 12)
    begin : g_bad_aw
        $error("AW must be 12: bank plus file address");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    phase_type phase_r, phase_nxt;
    logic busy_r, busy_nxt;
    logic nop_r, nop_nxt;
    logic taken_r, taken_nxt;
    instr_type ir_r, ir_nxt;
    logic [PC_W-1:0] pc_r, pc_nxt;
    logic [PC_W-1:0] target_r, target_nxt;
    logic [AW-1:0] addr_r, addr_nxt;
    byte_type val_r, val_nxt;
    logic ready_r, ready_nxt;
    logic ext_r, ext_nxt;
    logic [3:0] bank_r, bank_nxt;
    logic [2:0] flags_r, flags_nxt;
    logic [AW-1:0] ibase_r, ibase_nxt;
    logic [AW-1:0] maddr_r, maddr_nxt;
    logic ack_r, ack_nxt;
    word_type dat_r, dat_nxt;
    logic mpend_r, mpend_nxt;

    data_mem_if #(.AW(AW)) mem ();

    file_reg_mem #(.AW(AW)) u_mem (
        .clk_i (clk_i),
        .mem (mem.slave)
    );

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Returns {is conditional or always branch, branch passes}
    function automatic logic [1:0] branch_cond(input instr_type ins,
                                               input logic [2:0] fl);
        logic [1:0] r;
        r = 2'b00;
        if (ins[15:8] == `BX_OP_NOT_NEG)
        begin
            r = {1'b1, !fl[`BX_FLAG_N_BIT]};
        end
        else if (ins[15:8] == `BX_OP_NOT_OVF)
        begin
            r = {1'b1, !fl[`BX_FLAG_OV_BIT]};
        end
        else if (ins[15:8] == `BX_OP_NOT_ZERO)
        begin
            r = {1'b1, !fl[`BX_FLAG_Z_BIT]};
        end
        else if (ins[15:11] == `BX_OP_ALWAYS)
        begin
            r = 2'b11;
        end
        return r;
    endfunction

    function automatic logic [AW-1:0] file_addr(input instr_type ins,
                                                input logic ext,
                                                input logic [3:0] bank,
                                                input logic [AW-1:0] base);
        logic [AW-1:0] a;
        a = {bank, ins[7:0]};
        if (!ins[8])
        begin
            if (ext && ins[7:0] <= `BX_ACCESS_LIMIT)
            begin
                a = base + AW'(ins[7:0]);
            end
            else if (ins[7:0] <= `BX_ACCESS_LIMIT)
            begin
                a = AW'(ins[7:0]);
            end
            else
            begin
                a = {`BX_ACCESS_HIGH, ins[7:0]};
            end
        end
        return a;
    endfunction

    logic [1:0] cond_w;
    logic is_set_w;
    logic accept_w;
    logic [PC_W-1:0] off_w;
    byte_type set_val_w;

    assign cond_w = branch_cond(ir_r, flags_r);
    assign is_set_w = (ir_r[15:12] == `BX_OP_SET_BIT);
    assign accept_w = (phase_r == Q_DECODE) && !nop_r && instr_valid_i;
    // Offset doubled, sign-extended onto the incremented PC
    assign off_w = (ir_r[15:11] == `BX_OP_ALWAYS) ?
        {{(PC_W-12){ir_r[10]}}, ir_r[10:0], 1'b0} :
        {{(PC_W-9){ir_r[7]}}, ir_r[7:0], 1'b0};

    // One set lane per bit of the file byte
    for (genvar i = 0; i < 8; i++)
    begin : g_set_bit
        assign set_val_w[i] = mem.rdata[i] || (ir_r[11:9] == 3'(i));
    end

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    word_type wmask_w;
    logic req_w;
    logic mem_req_w;
    logic wr_flags_w;

    for (genvar i = 0; i < 4; i++)
    begin : g_lane
        assign wmask_w[8*i +: 8] = {8{wb_sel_i[i]}};
    end

    function automatic word_type merge(input word_type old,
                                       input word_type nw,
                                       input word_type m);
        return (old & ~m) | (nw & m);
    endfunction

    assign req_w = wb_cyc_i && wb_stb_i && !ack_r;
    assign mem_req_w = req_w && (wb_adr_i == `BX_OFF_MDATA);
    assign wr_flags_w = req_w && wb_we_i && (wb_adr_i == `BX_OFF_FLAGS);

    // ----------------------------------------------------------------
    // Execution and register next state
    // ----------------------------------------------------------------
    always_comb
    begin
        phase_nxt = phase_type'(phase_r + 2'b01);
        busy_nxt = busy_r;
        nop_nxt = nop_r;
        taken_nxt = taken_r;
        ir_nxt = ir_r;
        pc_nxt = pc_r;
        target_nxt = target_r;
        addr_nxt = addr_r;
        val_nxt = val_r;
        ext_nxt = ext_r;
        bank_nxt = bank_r;
        flags_nxt = flags_r;
        ibase_nxt = ibase_r;
        maddr_nxt = maddr_r;
        ack_nxt = 1'b0;
        dat_nxt = dat_r;
        mpend_nxt = mpend_r;
        mem.addr = addr_r;
        mem.wdata = val_r;
        mem.we = 1'b0;
        case (phase_r)
            Q_DECODE:
            begin
                busy_nxt = accept_w;
                if (accept_w)
                begin
                    ir_nxt = instr_i;
                    pc_nxt = pc_r + PC_W'(`BX_PC_STEP);
                end
                if (mem_req_w && !mpend_r)
                begin
                    // Memory window only in decode: no clash with Q2/Q4
                    mem.addr = maddr_r;
                    mem.wdata = wb_dat_i[7:0];
                    mem.we = wb_we_i && wb_sel_i[0];
                end
            end
            Q_READ:
            begin
                if (busy_r && is_set_w)
                begin
                    addr_nxt = file_addr(ir_r, ext_r, bank_r, ibase_r);
                    mem.addr = addr_nxt;
                end
            end
            Q_PROCESS:
            begin
                target_nxt = pc_r + off_w;
                taken_nxt = busy_r && cond_w[1] && cond_w[0];
                val_nxt = set_val_w;
            end
            Q_WRITE:
            begin
                nop_nxt = 1'b0;
                if (taken_r)
                begin
                    pc_nxt = target_r;
                    nop_nxt = 1'b1;
                end
                if (busy_r && is_set_w)
                begin
                    mem.we = 1'b1;
                end
                taken_nxt = 1'b0;
            end
            default:
            begin
                phase_nxt = Q_DECODE;
            end
        endcase
        if (req_w && !mem_req_w)
        begin
            ack_nxt = 1'b1;
            dat_nxt = '0;
            case (wb_adr_i)
                `BX_OFF_CTRL:
                begin
                    dat_nxt = 32'(ext_r);
                    if (wb_we_i && wb_sel_i[0])
                    begin
                        ext_nxt = wb_dat_i[`BX_CTRL_EXT_BIT];
                    end
                end
                `BX_OFF_BANK:
                begin
                    dat_nxt = 32'(bank_r);
                    if (wb_we_i && wb_sel_i[0])
                    begin
                        bank_nxt = wb_dat_i[3:0];
                    end
                end
                `BX_OFF_FLAGS:
                begin
                    dat_nxt = 32'(flags_r);
                    if (wb_we_i && wb_sel_i[0])
                    begin
                        flags_nxt = wb_dat_i[2:0];
                    end
                end
                `BX_OFF_IBASE:
                begin
                    dat_nxt = 32'(ibase_r);
                    if (wb_we_i)
                    begin
                        ibase_nxt = AW'(merge(32'(ibase_r), wb_dat_i,
                                              wmask_w));
                    end
                end
                `BX_OFF_PC:
                begin
                    dat_nxt = 32'(pc_r);
                    if (wb_we_i)
                    begin
                        // Software load overrides execution
                        pc_nxt = PC_W'(merge(32'(pc_r), wb_dat_i, wmask_w));
                    end
                end
                `BX_OFF_MADDR:
                begin
                    dat_nxt = 32'(maddr_r);
                    if (wb_we_i)
                    begin
                        maddr_nxt = AW'(merge(32'(maddr_r), wb_dat_i,
                                              wmask_w));
                    end
                end
                `BX_OFF_STATE:
                begin
                    dat_nxt = 32'({taken_r, phase_r, nop_r});
                end
                default:
                begin
                    dat_nxt = '0;
                end
            endcase
        end
        else if (mem_req_w && mpend_r)
        begin
            ack_nxt = 1'b1;
            dat_nxt = 32'(mem.rdata);
            mpend_nxt = 1'b0;
        end
        else if (mem_req_w && phase_r == Q_DECODE)
        begin
            // Reads wait one cycle for the registered memory data
            ack_nxt = wb_we_i;
            dat_nxt = '0;
            mpend_nxt = !wb_we_i;
        end
        ready_nxt = (phase_nxt == Q_DECODE) && !nop_nxt;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase_r <= Q_DECODE;
            busy_r <= 1'b0;
            nop_r <= 1'b0;
            taken_r <= 1'b0;
            ir_r <= '0;
            pc_r <= '0;
            target_r <= '0;
            addr_r <= '0;
            val_r <= '0;
            ready_r <= 1'b1;
            ext_r <= 1'b0;
            bank_r <= `BX_RST_BANK;
            flags_r <= `BX_RST_FLAGS;
            ibase_r <= `BX_RST_IBASE;
            maddr_r <= `BX_RST_MADDR;
            ack_r <= 1'b0;
            dat_r <= '0;
            mpend_r <= 1'b0;
        end
        else
        begin
            phase_r <= phase_nxt;
            busy_r <= busy_nxt;
            nop_r <= nop_nxt;
            taken_r <= taken_nxt;
            ir_r <= ir_nxt;
            pc_r <= pc_nxt;
            target_r <= target_nxt;
            addr_r <= addr_nxt;
            val_r <= val_nxt;
            ready_r <= ready_nxt;
            ext_r <= ext_nxt;
            bank_r <= bank_nxt;
            flags_r <= flags_nxt;
            ibase_r <= ibase_nxt;
            maddr_r <= maddr_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            mpend_r <= mpend_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign instr_ready_o = ready_r;
    assign pc_o = pc_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [1:0] in_cond_w;
    logic [PC_W-1:0] tgt8_w, tgt11_w, step_w;
    logic taken_in_w, cond_in_w, set_in_w;
    assign in_cond_w = branch_cond(instr_i, flags_r);
    assign step_w = PC_W'(`BX_PC_STEP);
    assign tgt8_w = pc_r + step_w +
        {{(PC_W-9){instr_i[7]}}, instr_i[7:0], 1'b0};
    assign tgt11_w = pc_r + step_w +
        {{(PC_W-12){instr_i[10]}}, instr_i[10:0], 1'b0};
    assign cond_in_w = accept_w && in_cond_w[1] &&
        (instr_i[15:11] != `BX_OP_ALWAYS);
    assign taken_in_w = cond_in_w && in_cond_w[0];
    assign set_in_w = accept_w && (instr_i[15:12] == `BX_OP_SET_BIT);

    sequence s_first_cycle;
        ##1 (pc_r == $past(pc_r) + step_w) ##1 $stable(pc_r) [*2];
    endsequence
    sequence s_nop_cycle;
        (nop_r && !ready_r) [*4] ##1 (!nop_r && ready_r);
    endsequence

    property p_not_neg;
        accept_w && instr_i[15:8] == `BX_OP_NOT_NEG &&
            !flags_r[`BX_FLAG_N_BIT] |-> ##4 pc_r == $past(tgt8_w, 4);
    endproperty
    a_not_neg: assert property (p_not_neg)
        else $error("negative-clear branch missed target");
    property p_not_ovf_skip;
        accept_w && instr_i[15:8] == `BX_OP_NOT_OVF &&
            flags_r[`BX_FLAG_OV_BIT] |->
            ##4 (pc_r == $past(pc_r, 4) + step_w && !nop_r);
    endproperty
    a_not_ovf_skip: assert property (p_not_ovf_skip)
        else $error("overflow-clear branch taken with overflow set");
    property p_not_zero;
        accept_w && instr_i[15:8] == `BX_OP_NOT_ZERO &&
            !flags_r[`BX_FLAG_Z_BIT] |-> ##4 pc_r == $past(tgt8_w, 4);
    endproperty
    a_not_zero: assert property (p_not_zero)
        else $error("zero-clear branch wrong target");
    property p_taken_nop;
        taken_in_w |-> ##4 s_nop_cycle;
    endproperty
    a_taken_nop: assert property (p_taken_nop)
        else $error("taken branch lacks one no-op cycle");
    property p_phases;
        taken_in_w |-> s_first_cycle ##1 (pc_r != $past(pc_r) || nop_r);
    endproperty
    a_phases: assert property (p_phases)
        else $error("branch PC written outside the write quarter");
    property p_always;
        accept_w && instr_i[15:11] == `BX_OP_ALWAYS |->
            ##4 pc_r == $past(tgt11_w, 4);
    endproperty
    a_always: assert property (p_always)
        else $error("unconditional branch wrong target");
    property p_always_two;
        accept_w && instr_i[15:11] == `BX_OP_ALWAYS |->
            ##3 phase_r == Q_WRITE ##1 s_nop_cycle;
    endproperty
    a_always_two: assert property (p_always_two)
        else $error("unconditional branch not two cycles");
    property p_set_bit;
        set_in_w |-> ##3 (mem.we && mem.addr == $past(mem.addr, 2) &&
            mem.wdata == ($past(mem.rdata) | (8'h01 << ir_r[11:9])));
    endproperty
    a_set_bit: assert property (p_set_bit)
        else $error("bit set wrote wrong value");
    property p_bank;
        set_in_w && instr_i[8] |=>
            mem.addr == {$past(bank_r), $past(instr_i[7:0])};
    endproperty
    a_bank: assert property (p_bank)
        else $error("banked address wrong");
    property p_indexed;
        set_in_w && !instr_i[8] && ext_r &&
            instr_i[7:0] <= `BX_ACCESS_LIMIT |=>
            mem.addr == $past(ibase_r) + AW'($past(instr_i[7:0]));
    endproperty
    a_indexed: assert property (p_indexed)
        else $error("indexed literal offset address wrong");
    property p_flags;
        !wr_flags_w |=> $stable(flags_r);
    endproperty
    a_flags: assert property (p_flags)
        else $error("status flags changed by execution");
endmodule
`default_nettype wire

// ===== dv/branch_and_bit_set_execute_tb.sv
// Self-checking bench for the branch and bit-set executor.
// Assumes the design files are compiled first, map header on include path.
`timescale 1ns/1ps
`default_nettype none
`include "bx_exec_map.svh"
module branch_and_bit_set_execute_tb;
    import bx_exec_pkg::*;
    localparam int PC_W = 21;
    localparam int LIMIT = 20000;
    logic clk_i;
    logic rst_i;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    word_type wb_dat_i;
    word_type wb_dat_o;
    logic wb_ack_o;
    instr_type instr_i;
    logic instr_valid_i;
    logic instr_ready_o;
    logic [PC_W-1:0] pc_o;
    int failures;
    int comparisons;
    int cycles;

    branch_and_bit_set_execute #(.PC_W(PC_W), .AW(12)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o),
        .pc_o(pc_o));

    // --------------------------------------------------------------
    // Clock and hang guard
    // --------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            failures++;
            results();
        end
    end

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic results();
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input word_type got, input word_type exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Registered outputs read right after the edge show pre-edge values
    task automatic wb(input logic we, input logic [7:0] adr,
                      input word_type dat, output word_type rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hf;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] adr, input word_type dat);
        word_type rd;
        wb(1'b1, adr, dat, rd);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input word_type exp);
        word_type rd;
        wb(1'b0, adr, 32'h0000_0000, rd);
        check(rd, exp);
    endtask

    // Returns clocks from accept to the next decode quarter with instr_ready_o high
    task automatic exec(input instr_type ins, output int k);
        @(posedge clk_i);
        instr_i <= ins;
        instr_valid_i <= 1'b1;
        do
            @(posedge clk_i);
        while (instr_ready_o !== 1'b1);
        instr_valid_i <= 1'b0;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (instr_ready_o !== 1'b1 && k < 40);
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    // Own flag set blocks; every other flag set still branches
    task automatic cond_branch(input byte_type op, input int fbit,
                               input int n);
        int k;
        wr(`BX_OFF_PC, 32'h0000_1000);
        wr(`BX_OFF_FLAGS, 32'h1 << fbit);
        exec({op, 8'(n)}, k);
        check(word_type'(pc_o), 32'h0000_1002);
        check(word_type'(k), 32'h0000_0004);
        wr(`BX_OFF_PC, 32'h0000_1000);
        wr(`BX_OFF_FLAGS, 32'h7 ^ (32'h1 << fbit));
        exec({op, 8'(n)}, k);
        check(word_type'(pc_o), word_type'(32'h1002 + 2 * n));
        check(word_type'(k), 32'h0000_0008);
        rd_chk(`BX_OFF_FLAGS, 32'h7 ^ (32'h1 << fbit));
    endtask

    // All flags set, so a conditional reading would refuse
    task automatic always_branch(input int n);
        int k;
        wr(`BX_OFF_PC, 32'h0000_1000);
        wr(`BX_OFF_FLAGS, 32'h0000_0007);
        exec({`BX_OP_ALWAYS, 11'(n)}, k);
        check(word_type'(pc_o), word_type'(32'h1002 + 2 * n));
        check(word_type'(k), 32'h0000_0008);
        rd_chk(`BX_OFF_FLAGS, 32'h0000_0007);
    endtask

    // Neighbour bits preset so a wide or misplaced write shows
    task automatic set_bit(input logic a, input byte_type f, input int b,
                           input logic [11:0] addr);
        int k;
        word_type old;
        old = 32'h5a & ~(32'h1 << b);
        wr(`BX_OFF_FLAGS, 32'h0000_0005);
        wr(`BX_OFF_MADDR, {20'h0_0000, addr});
        wr(`BX_OFF_MDATA, old);
        exec({`BX_OP_SET_BIT, 3'(b), a, f}, k);
        check(word_type'(k), 32'h0000_0004);
        wr(`BX_OFF_MADDR, {20'h0_0000, addr});
        rd_chk(`BX_OFF_MDATA, old | (32'h1 << b));
        rd_chk(`BX_OFF_FLAGS, 32'h0000_0005);
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0000_0000;
        instr_i = 16'h0000;
        instr_valid_i = 1'b0;
        failures = 0;
        comparisons = 0;
        cycles = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check(word_type'(pc_o), 32'h0000_0000);
        rd_chk(`BX_OFF_FLAGS, 32'h0000_0000);
        rd_chk(`BX_OFF_BANK, 32'h0000_0000);
        rd_chk(`BX_OFF_IBASE, 32'h0000_0000);
        wr(8'h20, 32'hffff_ffff);
        rd_chk(8'h20, 32'h0000_0000);
        cond_branch(`BX_OP_NOT_NEG, `BX_FLAG_N_BIT, -128);
        cond_branch(`BX_OP_NOT_OVF, `BX_FLAG_OV_BIT, 127);
        cond_branch(`BX_OP_NOT_ZERO, `BX_FLAG_Z_BIT, -3);
        always_branch(-1024);
        always_branch(1023);
        set_bit(1'b0, 8'h20, 0, 12'h020);
        set_bit(1'b0, 8'h80, 7, 12'hf80);
        wr(`BX_OFF_BANK, 32'h0000_0003);
        set_bit(1'b1, 8'h45, 3, 12'h345);
        wr(`BX_OFF_CTRL, 32'h0000_0001);
        wr(`BX_OFF_IBASE, 32'h0000_0200);
        set_bit(1'b0, 8'h5f, 5, 12'h25f);
        set_bit(1'b0, 8'h60, 2, 12'hf60);
        set_bit(1'b1, 8'h10, 6, 12'h310);
        results();
    end
endmodule
`default_nettype wire
